// ===== gdp_port_bank.sv
// Notes on behaviour
// R1: each pin has data bit and config register
// R2: data bits packed into six 8-bit registers
// R3: input pin read returns pin level
// R4: output pin driven from last written bit
// R5: data latched on each read and write
// R6: registers sit in relocatable event block
// R7: data registers at offsets 4b through 50
// R8: all pins gpio except bank c bits 4,5; code leaves bank b bit 3, bank d bits 7:4, bank f bits 7:2 unimplemented
// R9: bank d bits 7:4 reserved
// R10: bank e eight pins with serial alternates
// R11: config bit0 direction, bit1 polarity
// R12: write to input bit has no effect
// R13: read of output bit returns written value
// R14: reserved data bits read zero, ignore writes
// R15: alternate function routes pin to peripheral
//
// Local design decision: the AHB-Lite slave port.
module gdp_port_bank (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [47:0] pin_in,
    output logic      [47:0] pin_out,
    output logic      [47:0] pin_oe,
    output logic      [47:0] alt_in,
    input  wire logic [47:0] alt_out,
    input  wire logic [47:0] alt_oe
);

    // ************************************************************
    // state
    // ************************************************************
    gdp_pkg::gdp_bus_state_type state;
    gdp_pkg::gdp_bus_state_type next_state;

    logic [7:0]  base_index;        // event block base, in words
    logic [7:0]  cfg [gdp_pkg::PIN_COUNT];
    logic [7:0]  data [gdp_pkg::BANK_COUNT];
    logic [9:0]  addr_q;            // captured word index
    logic [9:0]  rel_q;             // captured block-relative index
    logic [47:0] sample;
    logic [47:0] dir_in;
    logic [47:0] pol;
    logic [47:0] alt_sel;
    logic [47:0] open_drain;
    logic        take;
    // decode of the captured transfer
    logic        wr_phase;          // write data phase, this cycle
    logic        rd_phase;          // read wait state, this cycle
    logic        base_hit;          // captured index is the base register
    logic        cfg_hit;           // captured index is a configuration register
    logic [2:0]  hit_bank;          // captured data bank, 7 when none
    logic [5:0]  cfg_pin;           // pin of the captured configuration register
    logic [7:0]  bank_msk [gdp_pkg::BANK_COUNT];
    logic [7:0]  hit_val;           // read value of the captured data bank
    logic [31:0] next_hrdata;

    // ************************************************************
    // address helpers
    // ************************************************************
    // data bank number of a relative index, 7 when none
    function automatic logic [2:0] data_bank(input logic [9:0] rel);
        logic [2:0] b;
        b = 3'h7;
        if (rel >= gdp_pkg::PIN_DATA_BANK_A && rel <= gdp_pkg::PIN_DATA_BANK_F)
        begin
            b = 3'(rel - gdp_pkg::PIN_DATA_BANK_A);              // [R7]
        end
        return b;
    endfunction : data_bank

    // true when a relative index hits a pin configuration register
    function automatic logic is_cfg(input logic [9:0] rel);
        return rel >= gdp_pkg::PIN_CFG_FIRST
            && rel < gdp_pkg::PIN_CFG_FIRST + 10'(gdp_pkg::PIN_COUNT);
    endfunction : is_cfg

    // ************************************************************
    // captured transfer decode
    // ************************************************************
    // data phase qualifiers, both held low while the clock enable is low
    assign wr_phase = ce && (state == gdp_pkg::GDP_WR_DATA);
    assign rd_phase = ce && (state == gdp_pkg::GDP_RD_WAIT);

    // base register wins when the block is moved over index 0
    assign base_hit = (addr_q == gdp_pkg::BASE_REG_INDEX);      // [R6]
    assign cfg_hit  = !base_hit && is_cfg(rel_q);
    assign hit_bank = base_hit ? 3'h7 : data_bank(rel_q);      // [R7]
    // only meaningful while cfg_hit is high
    assign cfg_pin  = 6'(rel_q - gdp_pkg::PIN_CFG_FIRST);

    // implemented bits of every bank, shared by write, read and pin paths
    always_comb
    begin
        for (int b = 0; b < gdp_pkg::BANK_COUNT; b++)
        begin
            bank_msk[b] = gdp_pkg::bank_mask(3'(b));            // [R14]
        end
    end

    // ************************************************************
    // bus handshake
    // ************************************************************
    // a valid single transfer seen in its address phase
    assign take = ce && hsel && hready
        && (htrans == gdp_pkg::HTRANS_NONSEQ || htrans == gdp_pkg::HTRANS_SEQ);

    // reads take one wait state so a preceding write has landed
    assign hreadyout = ce && (state != gdp_pkg::GDP_RD_WAIT);
    assign hresp     = gdp_pkg::HRESP_OKAY;

    // next bus state
    // a read always passes through one wait state
    always_comb
    begin
        next_state = state;
        unique case (state)
            gdp_pkg::GDP_IDLE,
            gdp_pkg::GDP_WR_DATA,
            gdp_pkg::GDP_RD_DATA:
            begin
                if (take)
                begin
                    next_state = hwrite ? gdp_pkg::GDP_WR_DATA : gdp_pkg::GDP_RD_WAIT;
                end
                else
                begin
                    next_state = gdp_pkg::GDP_IDLE;
                end
            end
            gdp_pkg::GDP_RD_WAIT:
            begin
                next_state = gdp_pkg::GDP_RD_DATA;
            end
        endcase
    end

    // bus state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= gdp_pkg::GDP_IDLE;
        end
        else if (ce)
        begin
            state <= next_state;
        end
    end

    // address phase capture, relative to the event block base
    // the relative index uses the base held at the address edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q <= 10'h000;
            rel_q  <= 10'h000;
        end
        else if (take)
        begin
            addr_q <= haddr[11:2];
            rel_q  <= haddr[11:2] - {2'h0, base_index};          // [R6]
        end
    end

    // ************************************************************
    // event block base register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            base_index <= gdp_pkg::BASE_RESET;
        end
        else if (wr_phase && base_hit)
        begin
            base_index <= hwdata[7:0];                           // [R6]
        end
    end

    // ************************************************************
    // pin configuration registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int p = 0; p < gdp_pkg::PIN_COUNT; p++)
            begin
                cfg[p] <= gdp_pkg::CFG_RESET;                    // [R1]
            end
            // infrared receive and transmit pins start in alternate use
            for (int i = 0; i < gdp_pkg::BANK_WIDTH; i++)
            begin
                if (gdp_pkg::BANK_C_ALT_DEF[i])
                begin
                    cfg[gdp_pkg::BANK_C * gdp_pkg::BANK_WIDTH + i] <= gdp_pkg::CFG_ALT_RESET; // [R8]
                end
            end
        end
        else if (wr_phase && cfg_hit)
        begin
            cfg[cfg_pin] <= hwdata[7:0];                         // [R1]
        end
    end

    // configuration fields as flat vectors
    // direction, polarity, alternate and drive type per pin
    always_comb
    begin
        for (int p = 0; p < gdp_pkg::PIN_COUNT; p++)
        begin
            dir_in[p]     = cfg[p][gdp_pkg::CFG_DIR_BIT];        // [R11]
            pol[p]        = cfg[p][gdp_pkg::CFG_POL_BIT];        // [R11]
            alt_sel[p]    = cfg[p][gdp_pkg::CFG_ALT_BIT];
            open_drain[p] = cfg[p][gdp_pkg::CFG_ODR_BIT];
        end
    end

    // ************************************************************
    // data registers
    // ************************************************************
    // latched on host read (input bits) and host write (output bits)
    // reserved bits are forced to zero in every enabled cycle in which the bank is the captured one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int b = 0; b < gdp_pkg::BANK_COUNT; b++)
            begin
                data[b] <= gdp_pkg::DATA_RESET;
            end
        end
        else if (ce)
        begin
            for (int b = 0; b < gdp_pkg::BANK_COUNT; b++)
            begin
                if (hit_bank == 3'(b))
                begin
                    for (int i = 0; i < gdp_pkg::BANK_WIDTH; i++)
                    begin
                        if (!bank_msk[b][i])
                        begin
                            data[b][i] <= 1'b0;                  // [R14] [R9]
                        end
                        else if (wr_phase && !dir_in[b * 8 + i])
                        begin
                            data[b][i] <= hwdata[i];             // [R4] [R5] [R12]
                        end
                        else if (rd_phase && dir_in[b * 8 + i])
                        begin
                            data[b][i] <= sample[b * 8 + i];     // [R3] [R5]
                        end
                    end
                end
            end
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // bank value: input bits show the pin, output bits the last write
    always_comb
    begin
        hit_val = 8'h00;
        if (hit_bank != 3'h7)
        begin
            for (int i = 0; i < gdp_pkg::BANK_WIDTH; i++)
            begin
                hit_val[i] = dir_in[hit_bank * 8 + i]
                    ? sample[hit_bank * 8 + i]                      // [R3]
                    : data[hit_bank][i] & bank_msk[hit_bank][i];    // [R13] [R14]
            end
        end
    end

    // read mux, upper bits always zero
    always_comb
    begin
        next_hrdata = 32'h0000_0000;
        if (base_hit)
        begin
            next_hrdata[7:0] = base_index;
        end
        else if (hit_bank != 3'h7)
        begin
            next_hrdata[7:0] = hit_val;
        end
        else if (cfg_hit)
        begin
            next_hrdata[7:0] = cfg[cfg_pin];
        end
    end

    // formed in the wait state, stands through the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_phase)
        begin
            hrdata <= next_hrdata;                               // [R5]
        end
    end

    // ************************************************************
    // pin paths, one per bank
    // ************************************************************
    for (genvar b = 0; b < gdp_pkg::BANK_COUNT; b++)
    begin : g_bank
        gdp_bank_pins u_pins (
            .dir_in     (dir_in[b * 8 +: 8]),
            .pol        (pol[b * 8 +: 8]),
            .alt_sel    (alt_sel[b * 8 +: 8]),
            .open_drain (open_drain[b * 8 +: 8]),
            .mask       (bank_msk[b]),
            .data       (data[b]),                               // [R2] [R10]
            .pin_in     (pin_in[b * 8 +: 8]),
            .alt_out    (alt_out[b * 8 +: 8]),
            .alt_oe     (alt_oe[b * 8 +: 8]),
            .pin_out    (pin_out[b * 8 +: 8]),
            .pin_oe     (pin_oe[b * 8 +: 8]),
            .alt_in     (alt_in[b * 8 +: 8]),
            .sample     (sample[b * 8 +: 8])
        );
    end

endmodule : gdp_port_bank

// ===== gdp_pkg.sv
package gdp_pkg;

    // ************************************************************
    // bank geometry
    // ************************************************************
    localparam int BANK_COUNT = 6;
    localparam int BANK_WIDTH = 8;
    localparam int PIN_COUNT  = BANK_COUNT * BANK_WIDTH;

    // ************************************************************
    // register indices, word address = 4 * index
    // ************************************************************
    // absolute index of the event block base register
    localparam logic [9:0] BASE_REG_INDEX   = 10'h000;
    // indices relative to the event block base
    localparam logic [9:0] PIN_DATA_BANK_A  = 10'h04b;
    localparam logic [9:0] PIN_DATA_BANK_B  = 10'h04c;
    localparam logic [9:0] PIN_DATA_BANK_C  = 10'h04d;
    localparam logic [9:0] PIN_DATA_BANK_D  = 10'h04e;
    localparam logic [9:0] PIN_DATA_BANK_E  = 10'h04f;
    localparam logic [9:0] PIN_DATA_BANK_F  = 10'h050;
    // first of 48 pin configuration registers, one per pin
    localparam logic [9:0] PIN_CFG_FIRST    = 10'h080;

    // ************************************************************
    // configuration register fields
    // ************************************************************
    localparam int CFG_DIR_BIT  = 0;   // 1 input, 0 output
    localparam int CFG_POL_BIT  = 1;   // 1 inverted
    localparam int CFG_ALT_BIT  = 2;   // 1 alternate function
    localparam int CFG_ODR_BIT  = 7;   // 1 open drain

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] BASE_RESET     = 8'h00;
    localparam logic [7:0] CFG_RESET      = 8'h01;
    localparam logic [7:0] CFG_ALT_RESET  = 8'h05;
    localparam logic [7:0] DATA_RESET     = 8'h00;
    // pins of bank c that come up in their alternate function
    localparam logic [7:0] BANK_C_ALT_DEF = 8'h30;
    localparam int         BANK_C         = 2;

    // ************************************************************
    // implemented bits of each data register
    // ************************************************************
    localparam logic [7:0] MASK_A = 8'hff;
    localparam logic [7:0] MASK_B = 8'hf7;
    localparam logic [7:0] MASK_C = 8'hff;
    localparam logic [7:0] MASK_D = 8'h0f;
    localparam logic [7:0] MASK_E = 8'hff;
    localparam logic [7:0] MASK_F = 8'h03;

    // ************************************************************
    // ahb-lite encodings
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum {
        GDP_IDLE,
        GDP_WR_DATA,
        GDP_RD_WAIT,
        GDP_RD_DATA
    } gdp_bus_state_type;

    // implemented bit mask of one bank
    function automatic logic [7:0] bank_mask(input logic [2:0] bank);
        logic [7:0] m;
        m = 8'h00;
        case (bank)
            3'h0: m = MASK_A;
            3'h1: m = MASK_B;
            3'h2: m = MASK_C;
            3'h3: m = MASK_D;
            3'h4: m = MASK_E;
            3'h5: m = MASK_F;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : bank_mask

endpackage : gdp_pkg

// ===== gdp_bank_pins.sv
// ************************************************************
// pin path of one eight-pin bank
// ************************************************************
module gdp_bank_pins (
    input  wire logic [7:0] dir_in,
    input  wire logic [7:0] pol,
    input  wire logic [7:0] alt_sel,
    input  wire logic [7:0] open_drain,
    input  wire logic [7:0] mask,
    input  wire logic [7:0] data,
    input  wire logic [7:0] pin_in,
    input  wire logic [7:0] alt_out,
    input  wire logic [7:0] alt_oe,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    output logic      [7:0] alt_in,
    output logic      [7:0] sample
);

    logic [7:0] gpio_val;
    logic [7:0] drive_en;

    // pin level as seen through the polarity bit
    assign sample   = (pin_in ^ pol) & mask;                     // [R3] [R11]
    assign alt_in   = pin_in ^ pol;

    // data bit drives an output pin, inverted when asked
    assign gpio_val = data ^ pol;                                // [R4] [R11]

    // alternate function takes the pin away from the data path
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (alt_sel[i])
            begin
                drive_en[i] = alt_oe[i];                         // [R15]
                pin_out[i]  = alt_out[i] ^ pol[i];
            end
            else
            begin
                drive_en[i] = ~dir_in[i];                        // [R11]
                pin_out[i]  = gpio_val[i];
            end
            // open drain only pulls low
            if (open_drain[i] && pin_out[i])
            begin
                drive_en[i] = 1'b0;
            end
            if (open_drain[i])
            begin
                pin_out[i] = 1'b0;
            end
            pin_oe[i] = drive_en[i] & mask[i];                   // [R14]
        end
    end

endmodule : gdp_bank_pins

// ===== gdp_pin_model.sv
// ************************************************************
// package pins as seen from the board
// ************************************************************
module gdp_pin_model (
    input  wire logic [47:0] pin_out,
    input  wire logic [47:0] pin_oe,
    input  wire logic [47:0] ext_level,
    output logic      [47:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // device drive wins where enabled, board level elsewhere
    always_comb
    begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    end

endmodule : gdp_pin_model

// ===== gdp_port_bank_asserts.sv
// ************************************************************
// bus and pin checks on the top ports
// ************************************************************
module gdp_port_bank_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] alt_oe
);
    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic taken;
    logic wr_dp;

    // transfer accepted at this edge
    assign taken = ce && hsel && hready && htrans[1];

    // high during the data phase of a write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_dp <= 1'b0;
        else
            wr_dp <= taken && hwrite;
    end

    sequence rd_taken;
        taken && !hwrite;
    endsequence
    sequence wait_then_data;
        !hreadyout ##1 (hreadyout || !ce);
    endsequence

    AST_RD_WAIT: assert property (rd_taken |=> wait_then_data)
        else $error("read wait state missing");
    AST_WR_ZERO: assert property (taken && hwrite |=> hreadyout || !ce)
        else $error("write data phase stalled");
    AST_CE_LOW: assert property (!ce |-> !hreadyout)
        else $error("ready while clock enable low");
    AST_HRESP: assert property (hresp == gdp_pkg::HRESP_OKAY)
        else $error("response not okay");
    AST_UPPER: assert property (hrdata[31:8] == 24'h0)
        else $error("read data above bit 7 set");
    AST_RSVD_OE: assert property (!pin_oe[11] && pin_oe[31:28] == 4'h0 && pin_oe[47:42] == 6'h0)
        else $error("reserved pin driven");
    AST_OE_CAUSE: assert property ($changed(pin_oe) && $stable(alt_oe) |-> $past(wr_dp))
        else $error("pin enable changed without a write");
    AST_RD_STANDS: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside wait state");
    AST_RESET_PINS: assert property ($rose(hresetn) |->
        (pin_oe & ~48'h30_0000) == 48'h0 && pin_oe[21:20] == alt_oe[21:20])
        else $error("pin enables wrong after reset");

endmodule : gdp_port_bank_asserts

bind gdp_port_bank gdp_port_bank_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_oe(pin_oe), .alt_oe(alt_oe)
);

// ===== gdp_port_bank_tb.sv
module gdp_port_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // signals
    // ************************************************************
    logic        hclk      = 1'b0;
    logic        hresetn   = 1'b0;
    logic        ce        = 1'b1;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [47:0] pin_in;
    logic [47:0] pin_out;
    logic [47:0] pin_oe;
    logic [47:0] alt_in;
    logic [47:0] alt_out   = 48'h30_0000;
    logic [47:0] alt_oe    = 48'h10_0000;
    logic [47:0] ext_level = 48'h3c5a_96a5_c3e1;
    logic [9:0]  base      = 10'h000;
    logic [7:0]  rd;
    logic [7:0]  msk [6];
    int          errors     = 0;
    int          num_checks = 0;

    // 10 MHz bus clock
    always #50 hclk = ~hclk;

    gdp_port_bank uut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_in(alt_in), .alt_out(alt_out), .alt_oe(alt_oe)
    );
    gdp_pin_model pins (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one single ahb-lite transfer, read byte left in rd
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= gdp_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {20'h0, idx, 2'h0};
        for (int ph = 0; ph < 2; ph++)
        begin
            n = 0;
            do
            begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            if (n >= 20)
            begin
                errors++;
                stop_test();
            end
            if (ph == 0)
            begin
                htrans <= 2'h0;
                hsel   <= 1'b0;
                hwdata <= {24'h0, wd};
            end
        end
        rd = hrdata[7:0];
    endtask : bus

    function automatic logic [9:0] bank(input int b);
        return base + gdp_pkg::PIN_DATA_BANK_A + 10'(b);
    endfunction : bank

    function automatic logic [9:0] cfg(input int p);
        return base + gdp_pkg::PIN_CFG_FIRST + 10'(p);
    endfunction : cfg

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        msk = '{gdp_pkg::MASK_A, gdp_pkg::MASK_B, gdp_pkg::MASK_C,
                gdp_pkg::MASK_D, gdp_pkg::MASK_E, gdp_pkg::MASK_F};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // all banks read pin levels, bank c alternates skipped
        for (int b = 0; b < 6; b++)
        begin
            bus(1'b0, bank(b), 8'h00);
            check(rd & ((b == 2) ? 8'hcf : 8'hff), ext_level[b*8 +: 8] & msk[b] & ((b == 2) ? 8'hcf : 8'hff));
        end
        bus(1'b0, 10'h000, 8'h00);
        check(rd, gdp_pkg::BASE_RESET);
        bus(1'b0, cfg(0), 8'h00);
        check(rd, gdp_pkg::CFG_RESET);
        bus(1'b0, cfg(20), 8'h00);
        check(rd, gdp_pkg::CFG_ALT_RESET);
        check(pin_oe[21:20], 2'b01);
        check(pin_out[20], 1'b1);
        check(pin_oe[19:0], 20'h0);
        // bank a outputs, pin 1 inverted
        for (int p = 0; p < 8; p++)
            bus(1'b1, cfg(p), (p == 1) ? 8'h02 : 8'h00);
        bus(1'b1, bank(0), 8'h5a);
        @(negedge hclk);
        check(pin_oe[7:0], 8'hff);
        check(pin_out[7:0], 8'h58);
        bus(1'b0, bank(0), 8'h00);
        check(rd, 8'h5a);
        // bank b stays input, inverted pin 8, levels change
        bus(1'b1, bank(1), 8'hff);
        @(negedge hclk);
        check(pin_oe[15:8], 8'h00);
        bus(1'b1, cfg(8), 8'h03);
        @(posedge hclk);
        ext_level <= ~ext_level;
        bus(1'b0, bank(1), 8'h00);
        check(rd, (ext_level[15:8] ^ 8'h01) & gdp_pkg::MASK_B);
        // bank d outputs incl. reserved bits
        for (int p = 24; p < 32; p++)
            bus(1'b1, cfg(p), 8'h00);
        bus(1'b1, bank(3), 8'hff);
        @(negedge hclk);
        check(pin_oe[31:24], 8'h0f);
        check(pin_out[27:24], 4'hf);
        bus(1'b0, bank(3), 8'h00);
        check(rd, 8'h0f);
        // bank e pin 35 to its alternate peripheral
        bus(1'b1, cfg(35), 8'h04);
        @(posedge hclk);
        alt_oe[35]  <= 1'b1;
        alt_out[35] <= 1'b1;
        @(negedge hclk);
        check(pin_oe[35], 1'b1);
        check(pin_out[35], 1'b1);
        check(alt_in[41:32], ext_level[41:32] | 10'h008);
        // bank e pin 36 open drain: drives only a low
        bus(1'b1, cfg(36), 8'h80);
        bus(1'b1, bank(4), 8'h00);
        @(negedge hclk);
        check({pin_oe[36], pin_out[36]}, 2'b10);
        bus(1'b1, bank(4), 8'h10);
        @(negedge hclk);
        check({pin_oe[36], pin_out[36]}, 2'b00);
        // relocate the event block
        bus(1'b1, 10'h000, 8'h10);
        base = 10'h010;
        bus(1'b0, bank(0), 8'h00);
        check(rd, 8'h5a);
        bus(1'b0, 10'h04b, 8'h00);
        check(rd, 8'h00);
        // clock enable low stalls the bus
        @(posedge hclk);
        ce <= 1'b0;
        @(negedge hclk);
        check(hreadyout, 1'b0);
        @(posedge hclk);
        ce <= 1'b1;
        stop_test();
    end

endmodule : gdp_port_bank_tb
